// ===== design/ofcm_defines.svh
// Offsets, field positions and reset values of the over-range flag block.
// Assumes word-aligned byte addresses on a 32-bit classic Wishbone bus.
`ifndef OFCM_DEFINES_SVH
`define OFCM_DEFINES_SVH

`define OFCM_ADR_W 8
`define OFCM_OFF_THRESH 8'h00
`define OFCM_OFF_HOLD 8'h04
`define OFCM_OFF_CLKOVR 8'h08
`define OFCM_OFF_STATUS 8'h0C
`define OFCM_OFF_MASK 8'h10
`define OFCM_OFF_LIVE 8'h14

`define OFCM_CLKOVR_EN 0
`define OFCM_CLKOVR_SEL_LO 1
`define OFCM_CLKOVR_DIS 3

`define OFCM_RST_THRESH 9'h100
`define OFCM_RST_HOLD 16'h0004
`define OFCM_RST_CLKOVR 4'h0
`define OFCM_RST_MASK 3'h0

`define OFCM_SEL_REF 2'h1
`define OFCM_SEL_DIV2 2'h2
`define OFCM_SEL_DIV4 2'h3

`endif

// ===== design/ofcm_pkg.sv
// Types of the over-range flag and clock output block.
// Needs nothing beyond the defines header.
package ofcm_pkg;

  typedef struct packed {
    logic valid;
    logic [8:0] a;
    logic [8:0] b;
    logic [8:0] c;
  } ofcm_samples_t;

  typedef struct packed {
    logic [2:0][15:0] hold_cnt;
    logic [2:0] flag;
    logic [8:0] threshold;
    logic [15:0] hold_len;
    logic [3:0] clk_ovr;
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] ref_cnt;
    logic c_out;
    logic ack;
    logic [31:0] rdata;
  } ofcm_state_t;

endpackage : ofcm_pkg

// ===== design/ofcm_top.sv
// Over-range flags for channels A..C and the channel C clock output mux.
// Assumes a classic Wishbone master and samples synchronous to REF_CLK_IN.
//
// Behaviour
// - A channel flag rises when its sample exceeds the programmed threshold.
// - A raised flag stays high at least the programmed hold length.
// - Channel B flag exists only in quad and dual variants.
// - Channel C over-range function exists only in the quad variant.
// - Channel C carries a clock only when selected and PLL enable high.
// - Select zero or register disable puts channel C flag on the pin.
// - Select 1 gives reference clock, 2 divided by two, 3 by four.
// - Clock appears from reset by pins alone, with PLL on and powered.
// - Power-down stops the reference clock and channel C clock.
`timescale 1ns/1ps
`include "ofcm_defines.svh"

module ofcm_top #(
  parameter int CHANNELS = 4
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [`OFCM_ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire ofcm_pkg::ofcm_samples_t SAMPLES_IN,
  input wire logic POWER_DOWN_PIN_IN,
  input wire logic PLL_EN_IN,
  input wire logic [1:0] CLOCK_OUT_SELECT_IN,
  output logic OVERRANGE_FLAG_A_OUT,
  output logic OVERRANGE_FLAG_B_OUT,
  output logic OVERRANGE_FLAG_C_OR_CLOCK_OUT,
  output logic PLL_REF_CLOCK_OUT,
  output logic IRQ_OUT
);
  import ofcm_pkg::*;

  localparam logic [2:0] PRESENT = (CHANNELS >= 4) ? 3'h7 :
                                   (CHANNELS >= 2) ? 3'h3 : 3'h1;

  ofcm_state_t s_q;
  ofcm_state_t s_d;
  logic [2:0][8:0] smp;
  logic [2:0] exc;
  logic [15:0] load;
  logic [1:0] sel_eff;
  logic clk_mode;
  logic running;
  logic req;
  logic commit;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Word view of each register; unmapped offsets read zero
  function automatic logic [31:0] reg_view(input ofcm_state_t s,
                                           input logic [`OFCM_ADR_W-1:0] a,
                                           input logic [3:0] live);
    case (a)
      `OFCM_OFF_THRESH: reg_view = {23'h0, s.threshold};
      `OFCM_OFF_HOLD: reg_view = {16'h0, s.hold_len};
      `OFCM_OFF_CLKOVR: reg_view = {28'h0, s.clk_ovr};
      `OFCM_OFF_STATUS: reg_view = {29'h0, s.status};
      `OFCM_OFF_MASK: reg_view = {29'h0, s.mask};
      `OFCM_OFF_LIVE: reg_view = {28'h0, live};
      default: reg_view = 32'h0;
    endcase
  endfunction : reg_view

  assign smp[0] = SAMPLES_IN.a;
  assign smp[1] = SAMPLES_IN.b;
  assign smp[2] = SAMPLES_IN.c;
  assign load = (s_q.hold_len == 16'h0) ? 16'h0 : s_q.hold_len - 16'h1;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      exc[i] = PRESENT[i] & SAMPLES_IN.valid & (smp[i] > s_q.threshold);
    end
  end

  assign sel_eff = !s_q.clk_ovr[`OFCM_CLKOVR_EN] ? CLOCK_OUT_SELECT_IN :
                   s_q.clk_ovr[`OFCM_CLKOVR_DIS] ? 2'h0 :
                   s_q.clk_ovr[`OFCM_CLKOVR_SEL_LO +: 2];
  // clock mode needs select and PLL enable
  assign clk_mode = (sel_eff != 2'h0) && PLL_EN_IN;
  assign running = PLL_EN_IN && !POWER_DOWN_PIN_IN;

  assign req = WB_CYC_IN && WB_STB_IN;
  assign commit = req && s_q.ack;

  always_comb begin
    logic [31:0] wv;
    logic [2:0] clr;
    wv = 32'h0;
    clr = 3'h0;
    s_d = s_q;
    for (int i = 0; i < 3; i++) begin
      if (exc[i]) begin
        s_d.hold_cnt[i] = load;
        s_d.flag[i] = 1'b1;
      end else if (SAMPLES_IN.valid && PRESENT[i]) begin
        // hold flag for the hold length
        if (s_q.hold_cnt[i] != 16'h0) begin
          s_d.hold_cnt[i] = s_q.hold_cnt[i] - 16'h1;
        end else begin
          s_d.flag[i] = 1'b0;
        end
      end
    end
    s_d.ref_cnt = running ? s_q.ref_cnt + 3'h1 : 3'h0;
    if (clk_mode) begin
      case (sel_eff)
        `OFCM_SEL_REF: s_d.c_out = s_d.ref_cnt[0];
        `OFCM_SEL_DIV2: s_d.c_out = s_d.ref_cnt[1];
        `OFCM_SEL_DIV4: s_d.c_out = s_d.ref_cnt[2];
        default: s_d.c_out = 1'b0;
      endcase
    end else begin
      // only the quad variant flags channel C
      s_d.c_out = s_d.flag[2] & PRESENT[2];
    end
    s_d.ack = req && !s_q.ack;
    s_d.rdata = reg_view(s_q, WB_ADR_IN,
                         {clk_mode, s_q.flag & PRESENT});
    if (commit && WB_WE_IN) begin
      wv = merge(reg_view(s_q, WB_ADR_IN, 4'h0), WB_DAT_IN, WB_SEL_IN);
      case (WB_ADR_IN)
        `OFCM_OFF_THRESH: s_d.threshold = wv[8:0];
        `OFCM_OFF_HOLD: s_d.hold_len = wv[15:0];
        `OFCM_OFF_CLKOVR: s_d.clk_ovr = wv[3:0];
        `OFCM_OFF_MASK: s_d.mask = wv[2:0];
        default: wv = 32'h0;
      endcase
    end
    if (commit && !WB_WE_IN && WB_ADR_IN == `OFCM_OFF_STATUS) begin
      clr = 3'h7;
    end
    // New flag rises win over a read clear
    s_d.status = (s_q.status & ~clr) | (s_d.flag & ~s_q.flag & PRESENT);
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_q <= '0;
      s_q.threshold <= `OFCM_RST_THRESH;
      s_q.hold_len <= `OFCM_RST_HOLD;
      s_q.clk_ovr <= `OFCM_RST_CLKOVR;
      s_q.mask <= `OFCM_RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign WB_ACK_OUT = s_q.ack;
  assign WB_DAT_OUT = s_q.rdata;
  assign OVERRANGE_FLAG_A_OUT = s_q.flag[0];
  // channel B only in quad and dual variants
  assign OVERRANGE_FLAG_B_OUT = s_q.flag[1] & PRESENT[1];
  assign OVERRANGE_FLAG_C_OR_CLOCK_OUT = s_q.c_out;
  assign PLL_REF_CLOCK_OUT = s_q.ref_cnt[0];
  assign IRQ_OUT = |(s_q.status & s_q.mask);

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  chk_flag_a_rise: assert property (
    exc[0] |=> OVERRANGE_FLAG_A_OUT)
    else $error("flag A not raised after exceedance");

  chk_hold_min_len: assert property (
    $fell(OVERRANGE_FLAG_A_OUT) |-> $past(s_q.hold_cnt[0]) == 16'h0)
    else $error("flag A dropped before hold expired");

  chk_hold_restart: assert property (
    exc[1] |=> s_q.hold_cnt[1] == $past(load))
    else $error("hold count not restarted");

  chk_b_absent_out: assert property (
    (CHANNELS < 2) |-> !OVERRANGE_FLAG_B_OUT)
    else $error("flag B driven in single variant");

  chk_c_flag_quad: assert property (
    (!clk_mode && CHANNELS < 4) |=> !OVERRANGE_FLAG_C_OR_CLOCK_OUT)
    else $error("flag C driven outside quad variant");

  chk_c_pll_gate: assert property (
    !PLL_EN_IN |=> OVERRANGE_FLAG_C_OR_CLOCK_OUT == (s_q.flag[2] & PRESENT[2]))
    else $error("clock on C without PLL enable");

  chk_c_flag_mode: assert property (
    (s_q.clk_ovr == 4'h9) |=>
      OVERRANGE_FLAG_C_OR_CLOCK_OUT == (s_q.flag[2] & PRESENT[2]))
    else $error("C not flag when clock disabled");

  chk_div4_source: assert property (
    (clk_mode && sel_eff == 2'h3) |=>
      OVERRANGE_FLAG_C_OR_CLOCK_OUT == s_q.ref_cnt[2])
    else $error("divide-by-four source wrong");

  chk_pin_clock_boot: assert property (
    (!s_q.clk_ovr[0] && running && CLOCK_OUT_SELECT_IN == 2'h1) [*2]
      |=> OVERRANGE_FLAG_C_OR_CLOCK_OUT != $past(OVERRANGE_FLAG_C_OR_CLOCK_OUT))
    else $error("pin-selected clock not toggling");

  chk_pd_stop_ref: assert property (
    POWER_DOWN_PIN_IN |=> !PLL_REF_CLOCK_OUT ##0 s_q.ref_cnt == 3'h0)
    else $error("reference clock runs in power-down");

  chk_flag_b_rise: assert property (
    exc[1]
      |=> OVERRANGE_FLAG_B_OUT)
    else $error("flag B not raised after exceedance");

  chk_flag_c_rise: assert property (
    (exc[2] && !clk_mode)
      |=> OVERRANGE_FLAG_C_OR_CLOCK_OUT)
    else $error("flag C not raised after exceedance");

  chk_a_rise_cause: assert property (
    $rose(OVERRANGE_FLAG_A_OUT)
      |-> $past(exc[0]))
    else $error("flag A rose without exceedance");

  chk_b_rise_cause: assert property (
    $rose(OVERRANGE_FLAG_B_OUT)
      |-> $past(exc[1]))
    else $error("flag B rose without exceedance");

  chk_c_rise_cause: assert property (
    $rose(s_q.flag[2])
      |-> $past(exc[2]))
    else $error("flag C rose without exceedance");

  chk_a_quiet_low: assert property (
    (SAMPLES_IN.valid && SAMPLES_IN.a <= s_q.threshold &&
     s_q.hold_cnt[0] == 16'h0)
      |=> !OVERRANGE_FLAG_A_OUT)
    else $error("flag A high below threshold");

  chk_b_quiet_low: assert property (
    (SAMPLES_IN.valid && SAMPLES_IN.b <= s_q.threshold &&
     s_q.hold_cnt[1] == 16'h0)
      |=> !OVERRANGE_FLAG_B_OUT)
    else $error("flag B high below threshold");

  chk_hold_b_len: assert property (
    $fell(OVERRANGE_FLAG_B_OUT)
      |-> $past(s_q.hold_cnt[1]) == 16'h0)
    else $error("flag B dropped before hold expired");

  chk_hold_c_len: assert property (
    $fell(s_q.flag[2])
      |-> $past(s_q.hold_cnt[2]) == 16'h0)
    else $error("flag C dropped before hold expired");

  chk_a_hold_high: assert property (
    s_q.hold_cnt[0] != 16'h0
      |-> OVERRANGE_FLAG_A_OUT)
    else $error("flag A low while hold runs");

  chk_b_hold_high: assert property (
    s_q.hold_cnt[1] != 16'h0
      |-> OVERRANGE_FLAG_B_OUT)
    else $error("flag B low while hold runs");

  chk_c_hold_high: assert property (
    s_q.hold_cnt[2] != 16'h0
      |-> s_q.flag[2])
    else $error("flag C low while hold runs");

  chk_a_hold_dec: assert property (
    (SAMPLES_IN.valid && !exc[0] &&
     s_q.hold_cnt[0] != 16'h0)
      |=> s_q.hold_cnt[0] == $past(s_q.hold_cnt[0]) - 16'h1)
    else $error("hold count A not stepped per sample");

  chk_b_hold_dec: assert property (
    (SAMPLES_IN.valid && !exc[1] &&
     s_q.hold_cnt[1] != 16'h0)
      |=> s_q.hold_cnt[1] == $past(s_q.hold_cnt[1]) - 16'h1)
    else $error("hold count B not stepped per sample");

  chk_a_hold_restart: assert property (
    exc[0]
      |=> s_q.hold_cnt[0] == $past(load))
    else $error("hold count A not restarted");

  chk_c_hold_restart: assert property (
    exc[2]
      |=> s_q.hold_cnt[2] == $past(load))
    else $error("hold count C not restarted");

  chk_flags_idle: assert property (
    !SAMPLES_IN.valid
      |=> $stable(s_q.flag))
    else $error("flags moved without a sample");

  chk_ref_source: assert property (
    (clk_mode && sel_eff == 2'h1)
      |=> OVERRANGE_FLAG_C_OR_CLOCK_OUT == s_q.ref_cnt[0])
    else $error("undivided source wrong");

  chk_div2_source: assert property (
    (clk_mode && sel_eff == 2'h2)
      |=> OVERRANGE_FLAG_C_OR_CLOCK_OUT == s_q.ref_cnt[1])
    else $error("divide-by-two source wrong");

  chk_c_flag_pins: assert property (
    (!s_q.clk_ovr[`OFCM_CLKOVR_EN] && CLOCK_OUT_SELECT_IN == 2'h0)
      |=> OVERRANGE_FLAG_C_OR_CLOCK_OUT == (s_q.flag[2] & PRESENT[2]))
    else $error("C not flag with select pins low");

  chk_pd_stop_c: assert property (
    (POWER_DOWN_PIN_IN && clk_mode)
      |=> !OVERRANGE_FLAG_C_OR_CLOCK_OUT)
    else $error("C clock runs in power-down");

  chk_ref_toggles: assert property (
    running
      |=> PLL_REF_CLOCK_OUT != $past(PLL_REF_CLOCK_OUT))
    else $error("reference clock not running");

endmodule : ofcm_top

// ===== verif/ofcm_fpga_model.sv
// Far-side logic model: counts rising edges seen on the channel C pin.
// Assumes the pin is sampled on the device clock, cleared by clr_in.
`timescale 1ns/1ps
module ofcm_fpga_model (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic c_in,
  output logic [7:0] edges_out
);
  logic c_q;
  always_ff @(posedge clk_in) begin
    c_q <= c_in;
    edges_out <= clr_in ? 8'h00 : edges_out + 8'(c_in & ~c_q);
  end
endmodule : ofcm_fpga_model

// ===== verif/tb_overrange_flag_and_clock_out_mux.sv
// Self-checking bench of the over-range flags and channel C clock mux.
// Assumes the design's default of four channels and full byte lanes.
`timescale 1ns/1ps
module tb_overrange_flag_and_clock_out_mux;
  import ofcm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, clr = 1'b0;
  logic pd = 1'b0, pll = 1'b1, ack, fa, fb, fc, pref, irq;
  logic [1:0] sel_pin = 2'h1;
  logic [7:0] adr = 8'h00, edges;
  logic [31:0] wdat = 32'h0, rdo, rdat;
  logic [15:0] rnd = 16'h000D;
  logic [8:0] thr = 9'h100;
  logic [2:0] mf = 3'h0, st = 3'h0;
  ofcm_samples_t smp = '0, s;
  int mc [3] = '{0, 0, 0};
  int hold, bad_count = 0, check_count = 0, cycles = 0;
  ofcm_top ofcm_top_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(cyc), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdo), .WB_ACK_OUT(ack),
    .SAMPLES_IN(smp), .POWER_DOWN_PIN_IN(pd), .PLL_EN_IN(pll),
    .CLOCK_OUT_SELECT_IN(sel_pin), .OVERRANGE_FLAG_A_OUT(fa),
    .OVERRANGE_FLAG_B_OUT(fb), .OVERRANGE_FLAG_C_OR_CLOCK_OUT(fc),
    .PLL_REF_CLOCK_OUT(pref), .IRQ_OUT(irq));
  ofcm_fpga_model ofcm_fpga_model_i (.clk_in(clk), .clr_in(clr), .c_in(fc),
    .edges_out(edges));
  initial forever #25 clk = ~clk;
  task automatic finish_test;
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test;
    end
  end
  task automatic cmp(input string n, input logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // Classic single cycle; waits for ack sampled at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk iff ack === 1'b1);
    rdat = rdo;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic clk_chk(input logic [1:0] sp, logic p, logic d, int e);
    @(posedge clk);
    sel_pin <= sp;
    pll <= p;
    pd <= d;
    clr <= 1'b1;
    repeat (4) @(posedge clk);
    clr <= 1'b0;
    repeat (16) @(posedge clk);
    #1;
    cmp("c edges", e, edges);
  endtask : clk_chk
  task automatic step(input ofcm_samples_t x);
    logic [8:0] v [3];
    v = '{x.a, x.b, x.c};
    for (int k = 0; k < 3 && x.valid; k++) begin
      if (v[k] > thr) begin
        st[k] |= ~mf[k];
        mf[k] = 1'b1;
        mc[k] = hold - 1;
      end else if (mc[k] > 0) begin
        mc[k]--;
      end else begin
        mf[k] = 1'b0;
      end
    end
  endtask : step
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    clk_chk(2'h1, 1'b1, 1'b0, 8);
    clk_chk(2'h2, 1'b1, 1'b0, 4);
    clk_chk(2'h3, 1'b1, 1'b0, 2);
    clk_chk(2'h0, 1'b1, 1'b0, 0);
    clk_chk(2'h3, 1'b0, 1'b0, 0);
    clk_chk(2'h1, 1'b1, 1'b1, 0);
    cmp("pll ref", 0, pref);
    @(posedge clk);
    pd <= 1'b0;
    wb(1'b0, 8'h00, 0);
    cmp("thresh", 32'h100, rdat);
    wb(1'b0, 8'h04, 0);
    cmp("hold", 32'h4, rdat);
    wb(1'b0, 8'h10, 0);
    cmp("mask", 0, rdat);
    wb(1'b0, 8'h20, 0);
    cmp("unmapped", 0, rdat);
    wb(1'b1, 8'h08, 32'h5);
    clk_chk(2'h1, 1'b1, 1'b0, 4);
    wb(1'b1, 8'h08, 32'h9);
    clk_chk(2'h1, 1'b1, 1'b0, 0);
    wb(1'b1, 8'h08, 32'h0);
    sel_pin <= 2'h0;
    for (int j = 0; j < 2; j++) begin
      rnd = lfsr(rnd);
      thr = {1'b0, rnd[7:0]} + 9'h080;
      hold = (j == 0) ? 1 : 3;
      wb(1'b1, 8'h00, 32'(thr));
      wb(1'b1, 8'h04, 32'(j * 3));
      for (int i = 0; i < 400; i++) begin
        @(posedge clk);
        step(smp);
        rnd = lfsr(rnd);
        s.a = rnd[8:0];
        s.valid = rnd[9] | rnd[10];
        rnd = lfsr(rnd);
        s.b = rnd[8:0];
        s.c = rnd[15:7];
        if (i == 0) begin
          s = {1'b1, thr, thr + 9'h001, 9'h1FF};
        end
        smp <= (i == 399) ? '0 : s;
        #1;
        cmp("flag a", mf[0], fa);
        cmp("flag b", mf[1], fb);
        cmp("flag c", mf[2], fc);
      end
    end
    wb(1'b1, 8'h10, 32'h1);
    @(posedge clk);
    #1;
    cmp("irq set", st[0], irq);
    wb(1'b0, 8'h0C, 0);
    cmp("status", st, rdat);
    @(posedge clk);
    #1;
    cmp("irq clear", 0, irq);
    finish_test;
  end
endmodule : tb_overrange_flag_and_clock_out_mux
